// ==== hdl/offset_prog_pkg.sv ====
// package: constants and types for the fifo offset programming host
package offset_prog_pkg;

  // serial load lengths, x9-to-x9 and other width modes, per depth variant 0..3
  localparam int SER_BITS_X9X9_BASE = 28;
  localparam int SER_BITS_STEP      = 2;
  localparam int SER_BITS_OTHER_DEC = 2;
  // parallel write/read counts
  localparam int PAR_OPS_X18        = 2;
  localparam int PAR_OPS_X9         = 4;
  localparam int PAR_OPS_X9X9_BIG   = 6;
  localparam int BIG_VARIANT        = 3;
  // flag settle after the completing write edge, in write-clock edges
  localparam int FLAG_SETTLE_EDGES  = 2;
  // bus widths
  localparam int BUS_W              = 18;
  localparam int OFFSET_W           = 17;
  localparam int MAX_OPS            = 6;
  localparam int MAX_BITS           = 34;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_SHIFT  = 3'b001,
    ST_PWRITE = 3'b010,
    ST_PREAD  = 3'b011,
    ST_SETTLE = 3'b100
  } host_state_t;

endpackage

// ==== hdl/offset_word_slicer.sv ====
// word slicer: picks the parallel word or serial bit for a step of an offset load
`timescale 1ns/1ps
module offset_word_slicer
  import offset_prog_pkg::*;
(
  // offsets to load
  input  wire logic [OFFSET_W-1:0] empty_offset,
  input  wire logic [OFFSET_W-1:0] full_offset,
  // configuration
  input  wire logic                 wide_in,
  input  wire logic [1:0]           variant,
  input  wire logic                 x9x9,
  // step index
  input  wire logic [5:0]           step,
  // results
  output logic      [BUS_W-1:0]     word,
  output logic                      bit_out
);

  logic [33:0] ser_stream;
  int          half_bits;

  // serial stream: empty low bits first, full high bits last
  always_comb
  begin
    half_bits  = SER_BITS_X9X9_BASE / 2 + int'(variant) - (x9x9 ? 0 : SER_BITS_OTHER_DEC / 2);
    ser_stream = '0;
    for (int i = 0; i < OFFSET_W; i++)
    begin
      if (i < half_bits)
      begin
        ser_stream[i] = empty_offset[i];
        ser_stream[(i + half_bits) % MAX_BITS] = full_offset[i];
      end
    end
    bit_out = ser_stream[step];
  end

  // parallel word: x18 sends halves of 17 bits, x9 sends a 9-bit low slice then an 8-bit high slice
  always_comb
  begin
    logic [OFFSET_W-1:0] src;
    logic [1:0]          part;
    src  = '0;
    part = 2'b00;
    word = '0;
    if (wide_in)
    begin
      src  = step[0] ? full_offset : empty_offset;
      word = {1'b0, src};
    end
    else
    begin
      if (x9x9 && variant == 2'(BIG_VARIANT))
      begin
        src  = (step >= 6'h03) ? full_offset : empty_offset;
        part = 2'((step >= 6'h03) ? step - 6'h03 : step);
      end
      else
      begin
        src  = step[1] ? full_offset : empty_offset;
        part = {1'b0, step[0]};
      end
      case (part)
        2'b00:   word = {9'h000, src[8:0]};
        2'b01:   word = {9'h000, 1'b0, src[16:9]};
        default: word = '0;
      endcase
    end
  end

endmodule

// ==== hdl/offset_prog_host.sv ====
// host controller that programs and reads back the fifo flag offsets
//
// Behaviour
// - shift one bit per write edge with load and shift enable low, empty low first
// - x9-to-x9 serial load is 28, 30, 32 or 34 bits by depth
// - other width modes shift two bits fewer
// - reprogramming serially always sends a complete new bit set
// - memory writes may interleave a serial load; shifting resumes next bit
// - pause serial by raising one of load or shift enable
// - x9-to-x9 parallel load takes four writes, six on largest variant
// - other modes: two writes for x18 input, four for x9 input
// - read and write offset pointers independent; never both in one period
// - parallel programming may pause; next write continues sequence
`timescale 1ns/1ps
module offset_prog_host
  import offset_prog_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // static configuration
  input  wire logic                 serial_mode,
  input  wire logic                 wide_in,
  input  wire logic                 wide_out,
  input  wire logic [1:0]           variant,
  input  wire logic                 fall_through_mode,
  // user command port
  input  wire logic                 start_load,
  input  wire logic                 start_read,
  input  wire logic                 hold,
  input  wire logic [OFFSET_W-1:0]  empty_offset,
  input  wire logic [OFFSET_W-1:0]  full_offset,
  output logic                      busy,
  output logic                      flags_valid,
  output logic                      read_done,
  output logic [OFFSET_W-1:0]       read_empty,
  output logic [OFFSET_W-1:0]       read_full,
  // device pins
  output logic                      offset_load_n,
  output logic                      serial_shift_enable_n,
  output logic                      serial_in,
  output logic                      write_enable_n,
  output logic                      read_enable_n,
  output logic                      master_reset_n,
  output logic                      serial_mode_sel,
  output logic [BUS_W-1:0]          data_in_bus,
  input  wire logic [BUS_W-1:0]     data_out_bus
);

  typedef struct packed
  {
    host_state_t         state;
    logic [5:0]          step;
    logic [5:0]          rstep;
    logic [5:0]          rsample;
    logic [1:0]          settle;
    logic                busy;
    logic                flags_valid;
    logic                read_done;
    logic [OFFSET_W-1:0] read_empty;
    logic [OFFSET_W-1:0] read_full;
    logic                ld_n;
    logic                sen_n;
    logic                si;
    logic                wen_n;
    logic                ren_n;
    logic                mrs_n;
    logic                mode_sel;
    logic [BUS_W-1:0]    din;
  } host_reg_t;

  host_reg_t   s_reg;
  host_reg_t   s_next;
  logic        x9x9;
  logic [5:0]  ser_total;
  logic [5:0]  par_total;
  logic [5:0]  rd_total;
  logic        rd_full;
  logic [5:0]  rd_part;
  logic [BUS_W-1:0] slice_word;
  logic        slice_bit;

  ////////////////////////////////////////////////////////////////////////////
  // sequence lengths from width mode and depth variant

  assign x9x9 = !wide_in && !wide_out;
  // serial length: 28 + 2*variant, two fewer outside x9-to-x9
  assign ser_total = 6'(SER_BITS_X9X9_BASE + SER_BITS_STEP * int'(variant)
                     - (x9x9 ? 0 : SER_BITS_OTHER_DEC));
  // parallel write count
  assign par_total = wide_in ? 6'(PAR_OPS_X18) :
                     (x9x9 && variant == 2'(BIG_VARIANT)) ? 6'(PAR_OPS_X9X9_BIG) :
                     6'(PAR_OPS_X9);
  // readback count follows the output width
  assign rd_total  = wide_out ? 6'(PAR_OPS_X18) :
                     (x9x9 && variant == 2'(BIG_VARIANT)) ? 6'(PAR_OPS_X9X9_BIG) :
                     6'(PAR_OPS_X9);
  // x9 readback slot of the next captured word: which offset, then low, high or spare part
  assign rd_full   = (rd_total == 6'(PAR_OPS_X9X9_BIG)) ? (s_reg.rsample >= 6'h03) :
                     s_reg.rsample[1];
  assign rd_part   = (rd_total != 6'(PAR_OPS_X9X9_BIG)) ? {5'h00, s_reg.rsample[0]} :
                     rd_full ? s_reg.rsample - 6'h03 : s_reg.rsample;

  offset_word_slicer u_slicer
  (
    .empty_offset (empty_offset),
    .full_offset  (full_offset),
    .wide_in      (wide_in),
    .variant      (variant),
    .x9x9         (x9x9),
    .step         (s_reg.step),
    .word         (slice_word),
    .bit_out      (slice_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_next = s_reg;
    s_next.read_done = 1'b0;
    s_next.mrs_n     = 1'b1;
    // the method pin may only move while master reset is still low
    if (!s_reg.mrs_n)
      s_next.mode_sel = serial_mode;
    case (s_reg.state)
      ST_IDLE:
      begin
        s_next.ld_n  = 1'b1;
        s_next.sen_n = 1'b1;
        s_next.wen_n = 1'b1;
        s_next.ren_n = 1'b1;
        s_next.busy  = 1'b0;
        // loads and reads never overlap, so both pointers stay apart
        if (start_load)
        begin
          s_next.busy        = 1'b1;
          s_next.flags_valid = 1'b0;
          s_next.step        = '0;
          s_next.state       = s_reg.mode_sel ? ST_SHIFT : ST_PWRITE;
        end
        else if (start_read)
        begin
          s_next.busy    = 1'b1;
          s_next.rstep   = '0;
          s_next.rsample = '0;
          s_next.state   = ST_PREAD;
        end
      end
      ST_SHIFT:
      begin
        // pausing raises shift enable only; load stays low
        s_next.ld_n  = 1'b0;
        s_next.wen_n = 1'b1;
        if (hold || s_reg.step >= ser_total)
          s_next.sen_n = 1'b1;
        else
        begin
          s_next.sen_n = 1'b0;
          s_next.si    = slice_bit;
          s_next.step  = s_reg.step + 6'h01;
        end
        if (s_reg.step >= ser_total && !s_reg.sen_n)
        begin
          s_next.sen_n  = 1'b1;
          s_next.settle = '0;
          s_next.state  = ST_SETTLE;
        end
      end
      ST_PWRITE:
      begin
        s_next.ld_n  = 1'b0;
        s_next.sen_n = 1'b1;
        if (hold || s_reg.step >= par_total)
          s_next.wen_n = 1'b1;
        else
        begin
          s_next.wen_n = 1'b0;
          s_next.din   = slice_word;
          s_next.step  = s_reg.step + 6'h01;
        end
        if (s_reg.step >= par_total && !s_reg.wen_n)
        begin
          s_next.wen_n  = 1'b1;
          s_next.settle = '0;
          s_next.state  = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        s_next.ld_n   = 1'b1;
        s_next.settle = s_reg.settle + 2'b01;
        if (s_reg.settle == 2'(FLAG_SETTLE_EDGES - 1))
        begin
          s_next.flags_valid = 1'b1;
          s_next.state       = ST_IDLE;
        end
      end
      ST_PREAD:
      begin
        s_next.ld_n = 1'b0;
        // a read lands at the edge that samples read enable low; its word stands after it
        if (s_reg.rsample != s_reg.rstep - 6'(!s_reg.ren_n))
        begin
          s_next.rsample = s_reg.rsample + 6'h01;
          if (wide_out)
          begin
            if (s_reg.rsample[0])
              s_next.read_full = data_out_bus[OFFSET_W-1:0];
            else
              s_next.read_empty = data_out_bus[OFFSET_W-1:0];
          end
          else if (rd_part == 6'h00 && rd_full)
            s_next.read_full[8:0] = data_out_bus[8:0];
          else if (rd_part == 6'h00)
            s_next.read_empty[8:0] = data_out_bus[8:0];
          else if (rd_part == 6'h01 && rd_full)
            s_next.read_full[16:9] = data_out_bus[7:0];
          else if (rd_part == 6'h01)
            s_next.read_empty[16:9] = data_out_bus[7:0];
        end
        if (hold || s_reg.rstep >= rd_total)
          s_next.ren_n = 1'b1;
        else
        begin
          s_next.ren_n = 1'b0;
          s_next.rstep = s_reg.rstep + 6'h01;
        end
        if (s_reg.rstep >= rd_total && s_reg.ren_n && s_reg.rsample == s_reg.rstep)
        begin
          s_next.read_done = 1'b1;
          s_next.state     = ST_IDLE;
        end
      end
      default:
        s_next.state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset pulses master reset and latches the programming method

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      s_reg          <= '0;
      s_reg.state    <= ST_IDLE;
      s_reg.ld_n     <= 1'b1;
      s_reg.sen_n    <= 1'b1;
      s_reg.wen_n    <= 1'b1;
      s_reg.ren_n    <= 1'b1;
      s_reg.mrs_n    <= 1'b0;
      // method pin loads each reset cycle and again on the edge where master reset rises
      s_reg.mode_sel <= serial_mode;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign busy                  = s_reg.busy;
  assign flags_valid           = s_reg.flags_valid;
  assign read_done             = s_reg.read_done;
  assign read_empty            = s_reg.read_empty;
  assign read_full             = s_reg.read_full;
  assign offset_load_n         = s_reg.ld_n;
  assign serial_shift_enable_n = s_reg.sen_n;
  assign serial_in             = s_reg.si;
  assign write_enable_n        = s_reg.wen_n;
  assign read_enable_n         = s_reg.ren_n;
  assign master_reset_n        = s_reg.mrs_n;
  assign serial_mode_sel       = s_reg.mode_sel;
  assign data_in_bus           = s_reg.din;

endmodule

// ==== sim/offset_prog_host_chk.sv ====
// checker: pin relations of the offset programming host
`timescale 1ns/1ps
module offset_prog_host_chk
  import offset_prog_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // configuration and command
  input wire logic       wide_in,
  input wire logic       wide_out,
  input wire logic [1:0] variant,
  input wire logic       start_load,
  input wire logic       start_read,
  // status
  input wire logic       busy,
  input wire logic       flags_valid,
  input wire logic       read_done,
  // device pins
  input wire logic       offset_load_n,
  input wire logic       serial_shift_enable_n,
  input wire logic       write_enable_n,
  input wire logic       read_enable_n,
  input wire logic       master_reset_n,
  input wire logic       serial_mode_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // strobe edges since the last start; a lost or doubled edge shows in the total
  logic [5:0] cnt_reg;
  logic       big;
  int         n_ser;
  int         n_wr;
  int         n_rd;
  assign big   = !wide_in && !wide_out && variant == BIG_VARIANT;
  assign n_ser = SER_BITS_X9X9_BASE + SER_BITS_STEP * int'(variant)
                 - ((wide_in || wide_out) ? SER_BITS_OTHER_DEC : 0);
  assign n_wr  = wide_in ? PAR_OPS_X18 : (big ? PAR_OPS_X9X9_BIG : PAR_OPS_X9);
  assign n_rd  = wide_out ? PAR_OPS_X18 : (big ? PAR_OPS_X9X9_BIG : PAR_OPS_X9);
  always_ff @(posedge clock)
  begin
    if (!resetn || (!busy && (start_load || start_read)))
      cnt_reg <= 6'h00;
    else if (!offset_load_n && !(serial_shift_enable_n && write_enable_n && read_enable_n))
      cnt_reg <= cnt_reg + 6'h01;
  end
  // named steps: a command taken, a load finished
  sequence s_take; !busy && master_reset_n && (start_load || start_read); endsequence
  sequence s_loaded; $rose(flags_valid); endsequence
  property p_take; s_take |=> busy; endproperty
  property p_mr; disable iff (1'b0) !resetn ##1 resetn |-> !master_reset_n; endproperty
  property p_quiet; !master_reset_n |-> offset_load_n && write_enable_n && read_enable_n
    && serial_shift_enable_n; endproperty
  property p_excl; !write_enable_n |-> read_enable_n; endproperty
  property p_shift; !serial_shift_enable_n |-> !offset_load_n && serial_mode_sel
    && write_enable_n; endproperty
  property p_mode; master_reset_n && $past(master_reset_n) |-> $stable(serial_mode_sel);
  endproperty
  property p_ser_len; s_loaded ##0 serial_mode_sel |-> cnt_reg == 6'(n_ser); endproperty
  property p_par_len; s_loaded ##0 !serial_mode_sel |-> cnt_reg == 6'(n_wr); endproperty
  property p_rd_len; read_done |-> cnt_reg == 6'(n_rd); endproperty
  a_take: assert property (p_take)
    else $error("command not taken");
  a_mr: assert property (p_mr)
    else $error("master reset not held after release");
  a_quiet: assert property (p_quiet)
    else $error("strobe active during master reset");
  a_excl: assert property (p_excl)
    else $error("read and write strobes low together");
  a_shift: assert property (p_shift)
    else $error("shift enable outside a serial load");
  a_mode: assert property (p_mode)
    else $error("method changed outside master reset");
  a_ser_len: assert property (p_ser_len)
    else $error("wrong serial bit count");
  a_par_len: assert property (p_par_len)
    else $error("wrong parallel write count");
  a_rd_len: assert property (p_rd_len)
    else $error("wrong readback count");
endmodule
bind offset_prog_host offset_prog_host_chk chk (.clock(clock), .resetn(resetn),
  .wide_in(wide_in), .wide_out(wide_out), .variant(variant), .start_load(start_load),
  .start_read(start_read), .busy(busy), .flags_valid(flags_valid), .read_done(read_done),
  .offset_load_n(offset_load_n), .serial_shift_enable_n(serial_shift_enable_n),
  .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
  .master_reset_n(master_reset_n), .serial_mode_sel(serial_mode_sel));

// ==== sim/fifo_offset_device_model.sv ====
// device model: offset registers, pointers and readback bus of the fifo
`timescale 1ns/1ps
module fifo_offset_device_model
  import offset_prog_pkg::*;
(
  // clock and configuration
  input  wire logic             clock,
  input  wire logic             wide_in,
  input  wire logic             wide_out,
  input  wire logic [1:0]       variant,
  // control pins and buses
  input  wire logic             master_reset_n,
  input  wire logic             serial_mode_sel,
  input  wire logic             offset_load_n,
  input  wire logic             serial_shift_enable_n,
  input  wire logic             serial_in,
  input  wire logic             write_enable_n,
  input  wire logic             read_enable_n,
  input  wire logic [BUS_W-1:0] data_in_bus,
  output logic      [BUS_W-1:0] data_out_bus
);
  logic [OFFSET_W-1:0] offs [2];
  logic [OFFSET_W-1:0] mask;
  logic                ser_sel;
  int                  wptr, rptr, sptr, nb, ps, pr, s, k;
  ////////////////////////////////////////////////////////////
  // write and read clocks are both the host clock; unused offset bits are dropped
  always @(posedge clock)
  begin
    nb = SER_BITS_X9X9_BASE + SER_BITS_STEP * int'(variant)
         - ((wide_in || wide_out) ? SER_BITS_OTHER_DEC : 0);
    mask = OFFSET_W'((1 << (nb / 2)) - 1);
    ps = wide_in ? 1 : ((!wide_out && variant == BIG_VARIANT) ? 3 : 2);
    pr = wide_out ? 1 : ((!wide_in && variant == BIG_VARIANT) ? 3 : 2);
    if (!master_reset_n)
    begin
      ser_sel = serial_mode_sel;
      wptr = 0;
      rptr = 0;
      sptr = 0;
      offs[0] = '0;
      offs[1] = '0;
      data_out_bus <= '0;
    end
    else if (!offset_load_n && !serial_shift_enable_n && ser_sel)
    begin
      // one bit per edge, whole set only; a pause keeps the bit position
      s = sptr / (nb / 2);
      k = sptr % (nb / 2);
      offs[s][k] = serial_in;
      sptr = (sptr + 1) % nb;
    end
    else if (!offset_load_n && !write_enable_n && !ser_sel)
    begin
      // next offset part in order, wrapping to the empty low part
      s = wptr / ps;
      k = wptr % ps;
      if (k == 0)
        offs[s][8:0] = data_in_bus[8:0];
      else if (k == 1)
        offs[s][16:9] = data_in_bus[7:0];
      if (wide_in)
        offs[s] = data_in_bus[OFFSET_W-1:0];
      offs[s] = offs[s] & mask;
      wptr = (wptr + 1) % (2 * ps);
    end
    // readback over the output bus only, either method and timing mode
    if (master_reset_n && !offset_load_n && !read_enable_n)
    begin
      s = rptr / pr;
      k = rptr % pr;
      if (wide_out)
        data_out_bus <= {1'b0, offs[s]};
      else
        data_out_bus <= {~data_out_bus[17:9], k == 0 ? offs[s][8:0] :
                         (k == 1 ? {1'b0, offs[s][16:9]} : 9'h000)};
      rptr = (rptr + 1) % (2 * pr);
    end
  end
endmodule

// ==== sim/fifo_flag_offset_programming_tb.sv ====
// testbench: random offset loads and readbacks against a device model
`timescale 1ns/1ps
module fifo_flag_offset_programming_tb
  import offset_prog_pkg::*;
;
  logic                clock, resetn, serial_mode, wide_in, wide_out, fall_through_mode;
  logic                start_load, start_read, hold, busy, flags_valid, read_done;
  logic                offset_load_n, serial_shift_enable_n, serial_in, write_enable_n;
  logic                read_enable_n, master_reset_n, serial_mode_sel, seen;
  logic [1:0]          variant;
  logic [OFFSET_W-1:0] empty_offset, full_offset, read_empty, read_full, mask;
  logic [OFFSET_W-1:0] exp_q [$];
  logic [BUS_W-1:0]    data_in_bus, data_out_bus;
  logic [31:0]         seed = 32'h00000034;
  logic [31:0]         r;
  int                  bad_count, comparisons, cycles, n, i;
  ////////////////////////////////////////////////////////////
  offset_prog_host dut (.clock(clock), .resetn(resetn), .serial_mode(serial_mode),
    .wide_in(wide_in), .wide_out(wide_out), .variant(variant),
    .fall_through_mode(fall_through_mode), .start_load(start_load),
    .start_read(start_read), .hold(hold), .empty_offset(empty_offset),
    .full_offset(full_offset), .busy(busy), .flags_valid(flags_valid),
    .read_done(read_done), .read_empty(read_empty), .read_full(read_full),
    .offset_load_n(offset_load_n), .serial_shift_enable_n(serial_shift_enable_n),
    .serial_in(serial_in), .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
    .master_reset_n(master_reset_n), .serial_mode_sel(serial_mode_sel),
    .data_in_bus(data_in_bus), .data_out_bus(data_out_bus));
  fifo_offset_device_model dev (.clock(clock), .wide_in(wide_in), .wide_out(wide_out),
    .variant(variant), .master_reset_n(master_reset_n), .serial_mode_sel(serial_mode_sel),
    .offset_load_n(offset_load_n), .serial_shift_enable_n(serial_shift_enable_n),
    .serial_in(serial_in), .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
    .data_in_bus(data_in_bus), .data_out_bus(data_out_bus));
  // xorshift source of stimulus
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // compares for status bits and offset words
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [OFFSET_W-1:0] got, input logic [OFFSET_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one command; hold pauses it at random, a second start during a serial load must be ignored
  task automatic run(input logic load);
    seen = 1'b0;
    start_load = load;
    start_read = 1'b1;
    @(negedge clock);
    start_load = 1'b0;
    start_read = 1'b0;
    check_bit(busy, 1'b1);
    if (load)
      check_bit(flags_valid, 1'b0);
    for (n = 0; busy === 1'b1 && n < 400; n++)
    begin
      r = xs();
      hold = r[1] & r[2];
      start_read = load && serial_mode && n == 3;
      seen = seen | (read_done === 1'b1);
      @(negedge clock);
    end
    hold = 1'b0;
    seen = seen | (read_done === 1'b1);
    check_bit(n < 400, 1'b1);
    for (i = 0; i < 4 && load && flags_valid !== 1'b1; i++)
      @(negedge clock);
    check_bit(load ? flags_valid : seen, 1'b1);
  endtask
  // clock at 100 ns period
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // cycle ceiling; a hang counts as a mismatch
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  // every depth variant in both methods, each behind its own master reset
  initial
  begin
    {resetn, start_load, start_read, hold, serial_mode, wide_in, wide_out} = 7'h00;
    {fall_through_mode, variant, empty_offset, full_offset} = '0;
    for (int t = 0; t < 8; t++)
    begin
      r = xs();
      serial_mode = t[0];
      variant = t[2:1];
      {wide_in, wide_out} = (t >= 6) ? 2'h0 : r[1:0];
      fall_through_mode = r[4];
      resetn = 1'b0;
      repeat (2) @(negedge clock);
      resetn = 1'b1;
      repeat (3) @(negedge clock);
      check_bit(flags_valid, 1'b0);
      n = SER_BITS_X9X9_BASE + SER_BITS_STEP * int'(variant)
          - ((wide_in || wide_out) ? SER_BITS_OTHER_DEC : 0);
      mask = OFFSET_W'((1 << (n / 2)) - 1);
      for (int j = 0; j < 2; j++)
      begin
        r = xs();
        empty_offset = r[16:0];
        r = xs();
        full_offset = r[16:0];
        exp_q = {empty_offset & mask, full_offset & mask};
        run(1'b1);
        for (int k = 0; k < 2; k++)
        begin
          run(1'b0);
          check_word(read_empty, exp_q[0]);
          check_word(read_full, exp_q[1]);
        end
      end
    end
    summarize();
  end
endmodule
